/* File: cfg_regfile.sv */
`timescale 1ns/1ps
// six byte registers, read data registered
module cfg_regfile (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_en_i,
  input  wire logic [2:0] wr_idx_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [2:0] rd_idx_i,
  output logic      [7:0] rd_data_o,
  output logic      [47:0] regs_o
);
  import port_cfg_pkg::*;

  typedef struct packed {
    logic [5:0][7:0] mem;
    logic [7:0]      rd;
  } rf_state_t;

  rf_state_t state;
  rf_state_t next_state;

  always_comb begin
    next_state = state;
    if (wr_en_i && (wr_idx_i < 3'(NUM_REGS))) begin
      next_state.mem[wr_idx_i] = wr_data_i;
    end
    next_state.rd = (rd_idx_i < 3'(NUM_REGS)) ? state.mem[rd_idx_i] : REG_RESET;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data_o = state.rd;
  assign regs_o    = state.mem;
endmodule : cfg_regfile

/* File: pad_model.sv */
`timescale 1ns/1ps
// pad side: an undriven, unpulled pin follows whatever the board puts on ext_i
module pad_model (
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pad_o
);
  assign pad_o = (oe_i & out_i) | (~oe_i & (pullup_i | ext_i));
endmodule : pad_model

/* File: port_cfg_monitor.sv */
`timescale 1ns/1ps
module port_cfg_monitor (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic       reg_hit_o,
  input wire logic       uart0_receive_o,
  input wire logic       timer_a_ext_clock_in_o,
  input wire logic       dac_output_o,
  input wire logic       brownout_reference_in_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] port1_pad_i,
  input wire logic [7:0] port1_oe_o,
  input wire logic [7:0] port1_out_o,
  input wire logic [7:0] port1_pullup_o,
  input wire logic [7:0] port1_analog_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire mapped = reg_addr_i inside {[8'he0:8'he5]};
  a_unmapped_read: assert property (
    reg_rd_i && !mapped |=> reg_rdata_o == 8'h00 && !reg_hit_o
  ) else $error("unmapped read answered");
  a_mapped_hit: assert property (
    reg_rd_i && mapped |=> reg_hit_o
  ) else $error("mapped read without hit");
  a_write_readback: assert property (
    reg_rd_i && mapped && $past(reg_wr_i) && $past(rst_n_i) && reg_addr_i == $past(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2)
  ) else $error("read after write mismatch");
  a_pushpull_pullup: assert property (
    (port1_oe_o & port1_out_o & port1_pullup_o) == 8'h00
  ) else $error("pull-up on while driving high");
  a_dac_route: assert property (
    dac_output_o == port1_analog_en_o[0] && !(dac_output_o && port1_pullup_o[0])
  ) else $error("dac route mismatch");
  a_bod_route: assert property (
    brownout_reference_in_o == port1_analog_en_o[1]
  ) else $error("brown-out route mismatch");
  a_rx0_sample: assert property (
    !uart0_receive_o |-> !port1_oe_o[2] && !$past(port1_pad_i[2])
  ) else $error("uart0 receive not from pad");
  a_tclk_sample: assert property (
    timer_a_ext_clock_in_o |-> !port1_oe_o[7] && $past(port1_pad_i[7])
  ) else $error("timer clock not from pad");
endmodule : port_cfg_monitor
bind port_pin_config port_cfg_monitor mon (.*);

/* File: port_cfg_pkg.sv */
// Function
// - port0_high_config, reset zero, fields from bit 7 down set port-0 pins 7..4: 00 input, 01 input with pull-up, 10 lcd drive, 11 push-pull output.
// - port0_low_config, reset zero, fields from bit 7 down set port-0 pins 3..0 with the same codes.
// - port-0 pins 0 and 1 take only backplane drive on the lcd code; pins 2..7 take segment drive bits 0..5.
// - port1_high_config, reset zero, fields from bit 7 down set port-1 pins 7..4.
// - port1_low_config, reset zero, fields from bit 7 down set port-1 pins 3..0.
// - port-1 pin 7: 00 input feeding the timer-a external clock, 01 not available, 10 lcd segment, 11 output.
// - port-1 pin 6: 00 input feeding timer-a capture, 01 timer-a toggle/pwm out, 10 lcd segment, 11 output.
// - port-1 pin 5: 00 input, 01 uart1 transmit, 10 lcd segment, 11 output.
// - port-1 pin 4: 00 input feeding uart1 receive, 01 uart1 receive-line out, 10 lcd segment, 11 output.
// - port-1 pin 3: 00 input, 01 uart0 transmit, 10 lcd segment, 11 output.
// - port-1 pin 2: 00 input feeding uart0 receive, 01 uart0 receive-line out, 10 lcd segment, 11 output.
// - port-1 pin 1: 00 input, 01 brown-out reference input, 10 not available, 11 output.
// - port-1 pin 0: 00 input, 01 dac output, 10 not available, 11 output.
// - in output mode a port-1 drain-mode bit picks push-pull (0) or open-drain (1).
// - a port-1 pull-up is off whenever the pin is push-pull output or an alternate function.
package port_cfg_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_PORT0_HIGH = 8'he0;
  localparam logic [7:0] ADDR_PORT0_LOW  = 8'he1;
  localparam logic [7:0] ADDR_PORT1_HIGH = 8'he2;
  localparam logic [7:0] ADDR_PORT1_LOW  = 8'he3;
  localparam logic [7:0] ADDR_PORT1_PUR  = 8'he4;
  localparam logic [7:0] ADDR_PORT1_DRN  = 8'he5;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam int         NUM_REGS        = 6;
  // ----------------------------------------
  // field codes
  // ----------------------------------------
  localparam logic [1:0] CODE_INPUT  = 2'h0;
  localparam logic [1:0] CODE_ALT1   = 2'h1;
  localparam logic [1:0] CODE_LCD    = 2'h2;
  localparam logic [1:0] CODE_OUTPUT = 2'h3;
endpackage : port_cfg_pkg

/* File: port_pin_config.sv */
`timescale 1ns/1ps
module port_pin_config (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register-addressed access port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_hit_o,
  // port 0 pads
  input  wire logic [7:0] port0_pad_i,
  input  wire logic [7:0] port0_data_i,
  output logic      [7:0] port0_out_o,
  output logic      [7:0] port0_oe_o,
  output logic      [7:0] port0_pullup_o,
  output logic      [7:0] port0_in_o,
  // port 1 pads
  input  wire logic [7:0] port1_pad_i,
  input  wire logic [7:0] port1_data_i,
  output logic      [7:0] port1_out_o,
  output logic      [7:0] port1_oe_o,
  output logic      [7:0] port1_pullup_o,
  output logic      [7:0] port1_in_o,
  output logic      [7:0] port1_analog_en_o,
  // lcd
  input  wire logic [7:0] lcd_segment_drive_i,
  input  wire logic [1:0] lcd_backplane_drive_i,
  // peripherals
  input  wire logic       timer_a_toggle_out_i,
  input  wire logic       uart1_transmit_i,
  input  wire logic       uart1_receive_out_i,
  input  wire logic       uart0_transmit_i,
  input  wire logic       uart0_receive_out_i,
  output logic            timer_a_ext_clock_in_o,
  output logic            timer_a_capture_in_o,
  output logic            uart1_receive_o,
  output logic            uart0_receive_o,
  output logic            brownout_reference_in_o,
  output logic            dac_output_o
);
  import port_cfg_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [1:0] field(input logic [15:0] cfg, input int pin);
    field = cfg[2*pin +: 2];
  endfunction : field

  function automatic logic [2:0] addr_index(input logic [7:0] a);
    addr_index = 3'(a - ADDR_PORT0_HIGH);
  endfunction : addr_index

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a >= ADDR_PORT0_HIGH) && (a <= ADDR_PORT1_DRN);
  endfunction : addr_ok

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [47:0] regs;
  logic [7:0]  rf_rdata;
  logic [15:0] p0_cfg;
  logic [15:0] p1_cfg;
  logic [7:0]  p1_pur;
  logic [7:0]  p1_drn;

  cfg_regfile u_regs (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (reg_wr_i && addr_ok(reg_addr_i)),
    .wr_idx_i  (addr_index(reg_addr_i)),
    .wr_data_i (reg_wdata_i),
    // the 3-bit index wraps past e7, so unmapped reads are steered to an empty slot
    .rd_idx_i  (addr_ok(reg_addr_i) ? addr_index(reg_addr_i) : 3'h7),
    .rd_data_o (rf_rdata),
    .regs_o    (regs)
  );

  // high byte holds pins 7..4, bit 7 first
  assign p0_cfg = {regs[7:0], regs[15:8]};
  assign p1_cfg = {regs[23:16], regs[31:24]};
  assign p1_pur = regs[39:32];
  assign p1_drn = regs[47:40];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p0_pu;
    logic [7:0] p0_in;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic [7:0] p1_pu;
    logic [7:0] p1_in;
    logic [7:0] p1_an;
    logic       hit;
    logic       ta_clk;
    logic       ta_cap;
    logic       u1_rx;
    logic       u0_rx;
    logic       bo_ref;
    logic       dac_en;
  } pin_state_t;

  pin_state_t state;
  pin_state_t next_state;
  logic [1:0] c;
  logic       drv;
  logic       alt;

  always_comb begin
    next_state     = state;
    c              = CODE_INPUT;
    drv            = 1'b0;
    alt            = 1'b0;
    next_state.hit = reg_rd_i && addr_ok(reg_addr_i);
    // ----------------------------------------
    // port 0
    // ----------------------------------------
    for (int i = 0; i < 8; i++) begin
      c = field(p0_cfg, i);
      next_state.p0_in[i] = port0_pad_i[i];
      next_state.p0_pu[i] = (c == CODE_ALT1);
      next_state.p0_oe[i] = (c == CODE_OUTPUT) || (c == CODE_LCD);
      if (c == CODE_LCD) begin
        next_state.p0_out[i] = (i < 2) ? lcd_backplane_drive_i[1'(i)]
                                       : lcd_segment_drive_i[3'(i - 2)];
      end else begin
        next_state.p0_out[i] = port0_data_i[i];
      end
    end
    // ----------------------------------------
    // port 1
    // ----------------------------------------
    for (int i = 0; i < 8; i++) begin
      c   = field(p1_cfg, i);
      drv = port1_data_i[i];
      alt = 1'b0;
      next_state.p1_an[i] = 1'b0;
      next_state.p1_in[i] = port1_pad_i[i];
      unique case (c)
        CODE_INPUT:  alt = 1'b0;
        CODE_OUTPUT: alt = 1'b0;
        CODE_LCD: begin
          // no lcd code on pins 0 and 1
          alt = (i >= 2);
          drv = lcd_segment_drive_i[i];
        end
        CODE_ALT1: begin
          unique case (i)
            7: alt = 1'b0;
            6: begin alt = 1'b1; drv = timer_a_toggle_out_i; end
            5: begin alt = 1'b1; drv = uart1_transmit_i; end
            4: begin alt = 1'b1; drv = uart1_receive_out_i; end
            3: begin alt = 1'b1; drv = uart0_transmit_i; end
            2: begin alt = 1'b1; drv = uart0_receive_out_i; end
            default: begin
              alt = 1'b0;
              next_state.p1_an[i] = 1'b1;
            end
          endcase
        end
      endcase
      next_state.p1_out[i] = drv;
      if (c == CODE_OUTPUT) begin
        // open-drain: drive only the low level
        next_state.p1_oe[i] = p1_drn[i] ? !drv : 1'b1;
      end else begin
        next_state.p1_oe[i] = alt;
      end
      next_state.p1_pu[i] = p1_pur[i] && !alt && !next_state.p1_an[i]
                            && !((c == CODE_OUTPUT) && !p1_drn[i]);
    end
    // ----------------------------------------
    // peripheral inputs
    // ----------------------------------------
    next_state.ta_clk = (field(p1_cfg, 7) == CODE_INPUT) && port1_pad_i[7];
    next_state.ta_cap = (field(p1_cfg, 6) == CODE_INPUT) && port1_pad_i[6];
    // idle-high uart lines when the pin is not a receive input
    next_state.u1_rx  = (field(p1_cfg, 4) == CODE_INPUT) ? port1_pad_i[4] : 1'b1;
    next_state.u0_rx  = (field(p1_cfg, 2) == CODE_INPUT) ? port1_pad_i[2] : 1'b1;
    next_state.bo_ref = (field(p1_cfg, 1) == CODE_ALT1);
    next_state.dac_en = (field(p1_cfg, 0) == CODE_ALT1);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state       <= '0;
      state.u1_rx <= 1'b1;
      state.u0_rx <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o             = rf_rdata;
  assign reg_hit_o               = state.hit;
  assign port0_out_o             = state.p0_out;
  assign port0_oe_o              = state.p0_oe;
  assign port0_pullup_o          = state.p0_pu;
  assign port0_in_o              = state.p0_in;
  assign port1_out_o             = state.p1_out;
  assign port1_oe_o              = state.p1_oe;
  assign port1_pullup_o          = state.p1_pu;
  assign port1_in_o              = state.p1_in;
  assign port1_analog_en_o       = state.p1_an;
  assign timer_a_ext_clock_in_o  = state.ta_clk;
  assign timer_a_capture_in_o    = state.ta_cap;
  assign uart1_receive_o         = state.u1_rx;
  assign uart0_receive_o         = state.u0_rx;
  assign brownout_reference_in_o = state.bo_ref;
  assign dac_output_o            = state.dac_en;
endmodule : port_pin_config

/* File: test_port_pin_config.sv */
`timescale 1ns/1ps
module test_port_pin_config;
  import port_cfg_pkg::*;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, ext0 = 8'h00, ext1 = 8'h00;
  logic [7:0] port0_data_i = 8'h00, port1_data_i = 8'h00, lcd_segment_drive_i = 8'h00;
  logic [1:0] lcd_backplane_drive_i = 2'h0;
  logic       timer_a_toggle_out_i = 1'b0, uart1_transmit_i = 1'b0, uart1_receive_out_i = 1'b0;
  logic       uart0_transmit_i = 1'b0, uart0_receive_out_i = 1'b0, reg_hit_o, dac_output_o;
  logic       timer_a_ext_clock_in_o, timer_a_capture_in_o, uart1_receive_o, uart0_receive_o;
  logic       brownout_reference_in_o;
  logic [7:0] reg_rdata_o, port0_pad_i, port0_out_o, port0_oe_o, port0_pullup_o, port0_in_o;
  logic [7:0] port1_pad_i, port1_out_o, port1_oe_o, port1_pullup_o, port1_in_o, port1_analog_en_o;
  logic [8:0] expq[$], q;
  int         errors = 0, cmp_count = 0, cyc = 0;
  port_pin_config uut (.*);
  pad_model pads0 (.oe_i(port0_oe_o), .out_i(port0_out_o), .pullup_i(port0_pullup_o),
                   .ext_i(ext0), .pad_o(port0_pad_i));
  pad_model pads1 (.oe_i(port1_oe_o), .out_i(port1_out_o), .pullup_i(port1_pullup_o),
                   .ext_i(ext1), .pad_o(port1_pad_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // one request per edge; strobes stay put between calls, so no double assignment
  task automatic bus(input logic w, r, input logic [7:0] a, d, input logic [8:0] e);
    if (r) expq.push_back(e);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
  endtask : bus
  task automatic pins(input logic [1:0] c, input logic od);
    logic [7:0] p, x, om, ev, e1;
    p = 8'($urandom);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 1'b0, 8'(8'he0 + i), i < 4 ? 8'h55 * c : (i == 4 ? p : {8{od}}), 9'h000);
    end
    {port0_data_i, port1_data_i, lcd_segment_drive_i, ext0, ext1} <= 40'({$urandom, $urandom});
    {lcd_backplane_drive_i, timer_a_toggle_out_i, uart1_transmit_i, uart1_receive_out_i,
     uart0_transmit_i, uart0_receive_out_i} <= 7'($urandom);
    bus(1'b0, 1'b0, 8'h00, 8'h00, 9'h000);
    repeat (3) @(posedge clk_i);
    #1;
    // out is only compared where some code can enable the driver
    om = (c == 2'h0) ? 8'h00 : (c == 2'h3 ? 8'hff : 8'hfc);
    ev = c == 0 ? 8'h00 : c == 1 ? 8'h7c : c == 2 ? 8'hfc : od ? ~port1_data_i : 8'hff;
    e1 = (c == 2'h2) ? lcd_segment_drive_i : port1_data_i;
    // pin 7 has no alternate under 01, so its out keeps the port data bit
    if (c == 2'h1) e1 = {port1_data_i[7], timer_a_toggle_out_i, uart1_transmit_i,
                         uart1_receive_out_i,
                         uart0_transmit_i, uart0_receive_out_i, 2'b00};
    x = p | ext1;
    chk("p1_oe", ev, port1_oe_o);
    chk("p1_pu", c == 0 ? p : c == 1 ? p & 8'h80 : c == 2 ? p & 8'h03 : od ? p : 8'h00,
        port1_pullup_o);
    chk("p1_out", e1 & om, port1_out_o & om);
    chk("periph", c == 0 ? {2'b00, x[7], x[6], x[4], x[2], 2'b00} : (c == 1 ? 8'h0f : 8'h0c),
        {2'b00, timer_a_ext_clock_in_o, timer_a_capture_in_o, uart1_receive_o,
         uart0_receive_o, brownout_reference_in_o, dac_output_o});
    chk("p1_analog", c == 2'h1 ? 8'h03 : 8'h00, port1_analog_en_o);
    chk("p0_oe", {8{c[1]}}, port0_oe_o);
    chk("p0_pu", {8{c == 2'h1}}, port0_pullup_o);
    chk("p0_out", c == 2 ? {lcd_segment_drive_i[5:0], lcd_backplane_drive_i} : port0_data_i & {8{c[1]}},
        port0_out_o & {8{c[1]}});
    if (c == 2'h0) begin
      chk("p1_in", x, port1_in_o);
      chk("p0_in", ext0, port0_in_o);
    end
    @(posedge clk_i);
  endtask : pins
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd_i;
    if (rd_d && expq.size() > 0) begin
      q = expq.pop_front();
      chk("rdata", q[7:0], reg_rdata_o);
      chk("hit", {7'h00, q[8]}, {7'h00, reg_hit_o});
    end
    if (cyc == 1000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0]  x, eo, ep;
    logic [15:0] p0c;
    void'($urandom(82263));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 1'b1, 8'(8'hdf + i), 8'h00, (i > 0 && i < 7) ? 9'h100 : 9'h000);
    end
    for (int i = 0; i < 7; i++) begin
      x = 8'($urandom);
      if (i < 2) p0c = {p0c[7:0], x};
      bus(1'b1, 1'b0, 8'(8'he0 + i), x, 9'h000);
      // last read goes to e8, which would alias e0 if the index wrapped
      bus(1'b0, 1'b1, (i < 6) ? 8'(8'he0 + i) : 8'he8, 8'h00,
          (i < 6) ? {1'b1, x} : 9'h000);
    end
    // mixed codes: each pin follows its own field, high byte first
    repeat (2) @(posedge clk_i);
    #1;
    for (int k = 0; k < 8; k++) begin
      eo[k] = p0c[2*k+1];
      ep[k] = (p0c[2*k +: 2] == CODE_ALT1);
    end
    chk("p0_oe_mix", eo, port0_oe_o);
    chk("p0_pu_mix", ep, port0_pullup_o);
    @(posedge clk_i);
    for (int c = 0; c < 5; c++) begin
      pins(2'(c > 3 ? 3 : c), c == 4);
    end
    repeat (3) @(posedge clk_i);
    print_verdict();
  end
endmodule : test_port_pin_config
